// [core/smd_address_map.sv]
// Purpose: Address map decoder and low system register bank
// Assumes: Single-cycle CPU strobes on ref_clk
// Notes:   Memories and peripheral slices sit outside
//
// Function
// - Accept 20-bit address spanning 00000h to FFFFFh.
// - ROM up to 48K ends at 0FFFFh, grows down; 48K ROM is 04000h-0FFFFh.
// - 0FFDCh-0FFFFh decode to the fixed interrupt vector table.
// - RAM starts at 00400h upward; 2.5K RAM spans to 00DFFh.
// - RAM serves data accesses and stack pushes and pops.
// - 00000h-002FFh decode to the peripheral register area.
// - 128K ROM runs contiguously 04000h to 23FFFh.
// - Count guard register resets to 00h, or 80h with option.
// - 80h applies when count guard initial option bit is zero.
// - Supply detect register two resets to 00h or bit 6 set.
// - Bit 6 set when startup byte enables low voltage detect 0 and the reset is not a POR or VMON1 reset.
`timescale 1ns/10ps
module smd_address_map
    import smd_pkg::*;
#(
    parameter int unsigned ROM_KB     = SMD_ROM_KB_DEF,
    parameter int unsigned RAM_BYTES  = SMD_RAM_BYTES_DEF,
    parameter logic [7:0]  FAST_OSCILLATOR_CONTROL_1_TRIM  = 8'h00
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [19:0] cpu_addr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_stack,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        count_guard_initial_option,
    input  wire logic        low_voltage_detect0_start,
    input  wire logic        por_or_vmon1_reset,
    input  wire logic [7:0]  periph_rdata,
    output logic             sel_sfr,
    output logic             sel_ram,
    output logic             sel_rom,
    output logic             sel_vec,
    output logic             sel_none,
    output logic             periph_sel,
    output logic [19:0]      ram_addr,
    output logic [19:0]      rom_addr,
    output logic             stack_fault,
    output logic [7:0]       cpu_rdata,
    output logic             cpu_rvalid
);

    // ========================================
    // Elaboration checks
    initial begin
        if (ROM_KB == 0 || ROM_KB > 960) begin
            $error("ROM size out of range");
        end
        if (RAM_BYTES == 0 || RAM_BYTES > 15360) begin
            $error("RAM size out of range");
        end
    end

    // ========================================
    // Region decode
    smd_target_t target;
    logic [19:0] ram_off;
    logic [19:0] rom_off;

    smd_region_decode #(
        .ROM_KB    (ROM_KB),
        .RAM_BYTES (RAM_BYTES)
    ) u_decode (
        .addr       (cpu_addr),
        .target     (target),
        .ram_offset (ram_off),
        .rom_offset (rom_off)
    );

    logic access;
    assign access = cpu_rd | cpu_wr;

    // ========================================
    // Register hit lookup
    logic [SMD_NREG-1:0] hit;
    logic                own_hit;
    logic                in_sfr;

    assign in_sfr = (target == SMD_TGT_SFR);

    genvar g;
    generate
        for (g = 0; g < SMD_NREG; g++) begin : g_hit
            assign hit[g] = in_sfr && (cpu_addr[9:0] == SMD_REG_ADDR[g]);
        end
    endgenerate

    assign own_hit = |hit;

    // ========================================
    // Startup-dependent reset values
    logic [7:0] rst_val [SMD_NREG];

    always_comb begin
        for (int i = 0; i < SMD_NREG; i++) begin
            rst_val[i] = SMD_REG_RST[i];
        end
        rst_val[SMD_IDX_FAST_OSCILLATOR_CONTROL_1] = FAST_OSCILLATOR_CONTROL_1_TRIM;
        if (!count_guard_initial_option) begin
            rst_val[SMD_IDX_CSGUARD] = SMD_CSGUARD_ALT;
        end
        if (low_voltage_detect0_start && !por_or_vmon1_reset) begin
            rst_val[SMD_IDX_VDET2] = SMD_VDET2_ALT;
            rst_val[SMD_IDX_VMON1] = SMD_VMON1_ALT;
        end
    end

    // ========================================
    // Register storage
    logic [7:0] reg_q [SMD_NREG];

    generate
        for (g = 0; g < SMD_NREG; g++) begin : g_reg
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    reg_q[g] <= rst_val[g];
                end else if (cpu_wr && hit[g]) begin
                    reg_q[g] <= cpu_wdata;
                end
            end
        end
    endgenerate

    // ========================================
    // Read data
    logic [7:0] own_rdata;

    always_comb begin
        own_rdata = SMD_READ_DEFAULT;
        for (int i = 0; i < SMD_NREG; i++) begin
            if (hit[i]) begin
                own_rdata = reg_q[i];
            end
        end
    end

    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    always_comb begin
        if (own_hit) begin
            rdata_d = own_rdata;
        end else if (in_sfr) begin
            rdata_d = periph_rdata;
        end else begin
            rdata_d = SMD_READ_DEFAULT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q  <= SMD_READ_DEFAULT;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cpu_rd;
            if (cpu_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cpu_rdata  = rdata_q;
    assign cpu_rvalid = rvalid_q;

    // ========================================
    // Target selects
    always_comb begin
        sel_sfr     = access && in_sfr;
        periph_sel  = access && in_sfr && !own_hit;
        sel_ram     = access && (target == SMD_TGT_RAM);
        sel_rom     = access && (target == SMD_TGT_ROM);
        sel_vec     = access && (target == SMD_TGT_VEC);
        sel_none    = access && (target == SMD_TGT_NONE);
        stack_fault = access && cpu_stack && (target != SMD_TGT_RAM);
        ram_addr    = ram_off;
        rom_addr    = rom_off;
    end

endmodule : smd_address_map

// [core/smd_pkg.sv]
// Purpose: Constants for the system address map decoder
// Assumes: 20-bit byte addresses, 8-bit register data
// Notes:   Register table is indexed by entry number
package smd_pkg;

    // ========================================
    // Address space
    localparam int unsigned  SMD_AW            = 20;
    localparam logic [19:0]  SMD_ADDR_LOW      = 20'h00000;
    localparam logic [19:0]  SMD_ADDR_HIGH     = 20'hfffff;
    localparam logic [19:0]  SMD_SFR_LOW       = 20'h00000;
    localparam logic [19:0]  SMD_SFR_HIGH      = 20'h002ff;
    localparam logic [19:0]  SMD_RAM_BASE      = 20'h00400;
    localparam logic [19:0]  SMD_ROM_TOP       = 20'h0ffff;
    localparam logic [19:0]  SMD_ROM_LOW_FIX   = 20'h04000;
    localparam logic [19:0]  SMD_VEC_LOW       = 20'h0ffdc;
    localparam logic [19:0]  SMD_VEC_HIGH      = 20'h0ffff;
    localparam int unsigned  SMD_ROM_SPLIT_KB  = 48;
    localparam int unsigned  SMD_ROM_KB_DEF    = 48;
    localparam int unsigned  SMD_RAM_BYTES_DEF = 2560;

    // ========================================
    // Register table
    localparam int unsigned  SMD_NREG = 24;

    localparam logic [9:0] SMD_REG_ADDR [SMD_NREG] = '{
        10'h004, 10'h005, 10'h006, 10'h007, 10'h00a, 10'h00c,
        10'h00d, 10'h00e, 10'h00f, 10'h010, 10'h011, 10'h012,
        10'h013, 10'h014, 10'h015, 10'h016, 10'h01c, 10'h023,
        10'h024, 10'h025, 10'h031, 10'h032, 10'h036, 10'h037
    };

    localparam logic [7:0] SMD_REG_RST [SMD_NREG] = '{
        8'h00, 8'h00, 8'h68, 8'h10, 8'h00, 8'h04,
        8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00
    };

    // Entries whose reset value depends on startup options
    localparam int unsigned  SMD_IDX_CSGUARD   = 16;
    localparam int unsigned  SMD_IDX_FAST_OSCILLATOR_CONTROL_1      = 18;
    localparam int unsigned  SMD_IDX_VDET2     = 21;
    localparam int unsigned  SMD_IDX_VMON1     = 22;
    localparam logic [7:0]   SMD_CSGUARD_ALT   = 8'h80;
    localparam logic [7:0]   SMD_VDET2_ALT     = 8'h40;
    localparam logic [7:0]   SMD_VMON1_ALT     = 8'h41;
    localparam logic [7:0]   SMD_READ_DEFAULT  = 8'h00;

    // ========================================
    // Decoded target
    typedef enum logic [4:0] {
        SMD_TGT_NONE = 5'b00001,
        SMD_TGT_SFR  = 5'b00010,
        SMD_TGT_RAM  = 5'b00100,
        SMD_TGT_ROM  = 5'b01000,
        SMD_TGT_VEC  = 5'b10000
    } smd_target_t;

endpackage : smd_pkg

// [core/smd_region_decode.sv]
// Purpose: Combinational region decode of a CPU address
// Assumes: ROM and RAM sizes fixed at elaboration
// Notes:   Vector table wins over ROM
`timescale 1ns/10ps
module smd_region_decode
    import smd_pkg::*;
#(
    parameter int unsigned ROM_KB    = SMD_ROM_KB_DEF,
    parameter int unsigned RAM_BYTES = SMD_RAM_BYTES_DEF
) (
    input  wire logic [19:0] addr,
    output smd_target_t      target,
    output logic [19:0]      ram_offset,
    output logic [19:0]      rom_offset
);

    // ========================================
    // Region bounds
    localparam logic [20:0] ROM_BYTES = 21'(ROM_KB * 1024);
    localparam logic [19:0] ROM_LOW   = (ROM_KB <= SMD_ROM_SPLIT_KB)
        ? 20'(21'h10000 - ROM_BYTES) : SMD_ROM_LOW_FIX;
    localparam logic [19:0] ROM_HIGH  = (ROM_KB <= SMD_ROM_SPLIT_KB)
        ? SMD_ROM_TOP : 20'(21'(SMD_ROM_LOW_FIX) + ROM_BYTES - 21'h1);
    localparam logic [19:0] RAM_HIGH  = 20'(21'(SMD_RAM_BASE) + 21'(RAM_BYTES) - 21'h1);

    // ========================================
    // Decode
    always_comb begin
        ram_offset = addr - SMD_RAM_BASE;
        rom_offset = addr - ROM_LOW;
        if (addr <= SMD_SFR_HIGH) begin
            target = SMD_TGT_SFR;
        end else if (addr >= SMD_RAM_BASE && addr <= RAM_HIGH) begin
            target = SMD_TGT_RAM;
        end else if (addr >= SMD_VEC_LOW && addr <= SMD_VEC_HIGH) begin
            target = SMD_TGT_VEC;
        end else if (addr >= ROM_LOW && addr <= ROM_HIGH) begin
            target = SMD_TGT_ROM;
        end else begin
            target = SMD_TGT_NONE;
        end
    end

endmodule : smd_region_decode

// [testbench/smd_address_map_monitor.sv]
// Purpose: Checker for the address map decoder
// Assumes: Bound to smd_address_map, ROM_KB of exactly 48
// Notes:   Sees top ports only
`timescale 1ns/10ps
module smd_address_map_monitor #(
    parameter int unsigned ROM_KB = 48,
    parameter int unsigned RAM_BYTES = 2560
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [19:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_stack,
    input wire logic [7:0] cpu_wdata,
    input wire logic sel_sfr,
    input wire logic sel_ram,
    input wire logic sel_rom,
    input wire logic sel_vec,
    input wire logic sel_none,
    input wire logic [19:0] ram_addr,
    input wire logic [19:0] rom_addr,
    input wire logic stack_fault,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid
);
    // ========================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic acc_on = cpu_rd | cpu_wr;
    sequence s_wr4; cpu_wr && cpu_addr == 20'h00004; endsequence
    sequence s_rd4; cpu_rd && cpu_addr == 20'h00004; endsequence
    property p_wrrd; s_wr4 ##1 s_rd4 |=> cpu_rdata == $past(cpu_wdata, 2); endproperty
    a_wrrd: assert property (p_wrrd) else $error("register read back differs");
    property p_rdv; cpu_rd |=> cpu_rvalid; endproperty
    a_rdv: assert property (p_rdv) else $error("read not answered");
    property p_norv; !cpu_rd |=> !cpu_rvalid; endproperty
    a_norv: assert property (p_norv) else $error("answer without read");
    property p_sfr; acc_on && cpu_addr <= 20'h002ff |-> sel_sfr && !sel_none; endproperty
    a_sfr: assert property (p_sfr) else $error("register area missed");
    property p_ram;
        acc_on && cpu_addr inside {[20'h00400:20'h00dff]} |-> sel_ram && ram_addr == cpu_addr - 20'h00400;
    endproperty
    a_ram: assert property (p_ram) else $error("ram decode wrong");
    property p_rom;
        acc_on && cpu_addr inside {[20'h04000:20'h0ffdb]} |-> sel_rom && rom_addr == cpu_addr - 20'h04000;
    endproperty
    a_rom: assert property (p_rom) else $error("rom decode wrong");
    property p_vec; acc_on && cpu_addr >= 20'h0ffdc && cpu_addr <= 20'h0ffff |-> sel_vec && !sel_rom; endproperty
    a_vec: assert property (p_vec) else $error("vector decode wrong");
    property p_none; cpu_rd && cpu_addr > 20'h0ffff |-> sel_none ##1 cpu_rdata == 8'h00; endproperty
    a_none: assert property (p_none) else $error("unmapped read wrong");
    property p_stk; cpu_stack && acc_on |-> stack_fault == !sel_ram; endproperty
    a_stk: assert property (p_stk) else $error("stack fault wrong");
endmodule : smd_address_map_monitor

// [testbench/smd_periph_model.sv]
// Purpose: Peripheral slice on the decoded side
// Assumes: Answers in the cycle of the read
// Notes:   Idle bus shows a moving pattern
`timescale 1ns/10ps
module smd_periph_model (
    input wire logic ref_clk,
    input wire logic [19:0] cpu_addr,
    input wire logic periph_sel,
    output logic [7:0] periph_rdata
);
    logic [7:0] noise_q = 8'h00;
    always @(posedge ref_clk) begin
        noise_q <= noise_q + 8'h35;
    end
    // Reserved slots answer an address tag
    assign periph_rdata = periph_sel ? (cpu_addr[7:0] ^ 8'ha5) : noise_q;
endmodule : smd_periph_model

// [testbench/system_address_map_decoder_tb.sv]
// Purpose: Self-checking bench of the address map decoder
// Assumes: Read data one cycle after the strobe
// Notes:   Register model is an array of bytes
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module system_address_map_decoder_tb;
    import smd_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, cpu_rd = 1'b0, cpu_wr = 1'b0, cpu_stack = 1'b0;
    logic cg_opt = 1'b1, lv_opt = 1'b0, por_opt = 1'b1, rv_v;
    logic [19:0] cpu_addr = 20'h00000, ram_addr, rom_addr;
    logic [7:0] cpu_wdata = 8'h00, periph_rdata, cpu_rdata, rd_v;
    logic sel_sfr, sel_ram, sel_rom, sel_vec, sel_none, periph_sel, stack_fault, cpu_rvalid;
    logic [4:0] sel_v;
    logic ps_v;
    logic [7:0] mdl [SMD_NREG];
    logic [19:0] bnd [$] = '{20'h00000, 20'h002ff, 20'h00300, 20'h003ff, 20'h00400, 20'h00dff,
        20'h00e00, 20'h03fff, 20'h04000, 20'h0ffdb, 20'h0ffdc, 20'h0ffff, 20'h10000, 20'hfffff};
    int fails = 0, tests_run = 0, seed = 32'hb3d8;
    smd_address_map i_dut (.ref_clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_stack, .cpu_wdata,
        .count_guard_initial_option(cg_opt), .low_voltage_detect0_start(lv_opt),
        .por_or_vmon1_reset(por_opt), .periph_rdata, .sel_sfr, .sel_ram, .sel_rom, .sel_vec,
        .sel_none, .periph_sel, .ram_addr, .rom_addr, .stack_fault, .cpu_rdata, .cpu_rvalid);
    smd_periph_model i_per (.ref_clk, .cpu_addr, .periph_sel, .periph_rdata);
    always #50 ref_clk = ~ref_clk;
    // ========================================
    // Tasks
    function automatic logic [4:0] xsel(input logic [19:0] a);
        if (a <= 20'h002ff) return 5'h10;
        if (a >= 20'h00400 && a <= 20'h00dff) return 5'h08;
        if (a >= 20'h0ffdc && a <= 20'h0ffff) return 5'h02;
        if (a >= 20'h04000 && a <= 20'h0ffff) return 5'h04;
        return 5'h01;
    endfunction : xsel
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic acc(input logic [19:0] a, input logic w, input logic [7:0] d, input logic s);
        @(negedge ref_clk);
        {cpu_addr, cpu_rd, cpu_wr, cpu_wdata, cpu_stack} = {a, ~w, w, d, s};
        #1 sel_v = {sel_sfr, sel_ram, sel_rom, sel_vec, sel_none};
        ps_v = periph_sel;
        @(posedge ref_clk);
        #1 {rd_v, rv_v} = {cpu_rdata, cpu_rvalid};
    endtask : acc
    task automatic do_reset(input logic cg, input logic lv, input logic po);
        @(negedge ref_clk);
        {rst, cpu_rd, cpu_wr, cpu_stack, cg_opt, lv_opt, por_opt} = {4'b1000, cg, lv, po};
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        {mdl[2], mdl[3], mdl[5], mdl[8], mdl[20]} = {8'h68, 8'h10, 8'h04, 8'h1f, 8'h08};
        if (!cg) mdl[16] = 8'h80;
        if (lv && !po) {mdl[21], mdl[22]} = {8'h40, 8'h41};
        foreach (mdl[i]) begin
            acc({10'h000, SMD_REG_ADDR[i]}, 1'b0, 8'h00, 1'b0);
            `CHK("reset value", mdl[i], rd_v)
        end
    endtask : do_reset
    // ========================================
    // Sequence
    initial begin
        do_reset(1'b1, 1'b0, 1'b1);
        foreach (mdl[i]) begin
            mdl[i] = 8'($random(seed));
            acc({10'h000, SMD_REG_ADDR[i]}, 1'b1, mdl[i], 1'b0);
            acc({10'h000, SMD_REG_ADDR[i]}, 1'b0, 8'h00, 1'b0);
            `CHK("readback", mdl[i], rd_v)
            `CHK("own register select", 1'b0, ps_v)
        end
        acc(20'h0000b, 1'b1, 8'h3c, 1'b0);
        acc(20'h0000a, 1'b0, 8'h00, 1'b0);
        `CHK("reserved write", mdl[4], rd_v)
        acc(20'h00000, 1'b0, 8'h00, 1'b0);
        `CHK("reserved read", 8'ha5, rd_v)
        `CHK("reserved select", 1'b1, ps_v)
        acc(20'h12345, 1'b1, 8'h3c, 1'b0);
        acc(20'h12345, 1'b0, 8'h00, 1'b0);
        `CHK("unmapped read", 8'h00, rd_v)
        `CHK("unmapped select", 1'b0, ps_v)
        repeat (8) bnd.push_back(20'($random(seed)));
        foreach (bnd[i]) begin
            acc(bnd[i], 1'b0, 8'h00, bnd[i][0]);
            `CHK("region", xsel(bnd[i]), sel_v)
            `CHK("stack", bnd[i][0] && xsel(bnd[i]) != 5'h08, stack_fault)
            `CHK("answer", 1'b1, rv_v)
        end
        do_reset(1'b0, 1'b1, 1'b0);
        do_reset(1'b1, 1'b1, 1'b1);
        give_verdict();
    end
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
endmodule : system_address_map_decoder_tb
bind smd_address_map smd_address_map_monitor #(.ROM_KB(ROM_KB), .RAM_BYTES(RAM_BYTES)) i_mon (
    .ref_clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_stack, .cpu_wdata, .sel_sfr, .sel_ram,
    .sel_rom, .sel_vec, .sel_none, .ram_addr, .rom_addr, .stack_fault, .cpu_rdata, .cpu_rvalid);
